// ==== hdl/serial_pin_mux.sv ====
// Pin direction selection for the serial port pins
`timescale 1ns/1ps
module serial_pin_mux (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	pin_cfg_if.mux cfg
);
	wire logic mst = cfg.enable & cfg.master;
	wire logic slv = cfg.enable & ~cfg.master;
	wire logic bidir = cfg.pin_ctl;

	// Enable low means the pin is driven
	assign cfg.mosi_oe_n = ~(mst & (~bidir | cfg.bidir_oe));
	assign cfg.miso_oe_n = ~(slv & (~bidir | cfg.bidir_oe));
	assign cfg.ss_oe_n = ~(mst & cfg.mode_fault_flag_en & cfg.ss_oe);
	assign cfg.sck_oe_n = ~mst;
	// Receive pin: mosi for slave normal and master bidirectional
	assign cfg.rx_on_mosi = (mst & bidir) | (slv & ~bidir);
	assign cfg.ss_fault_in = mst & cfg.mode_fault_flag_en & ~cfg.ss_oe;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);

	property p_bidir_master_off;
		(mst & bidir & ~cfg.bidir_oe) |-> (cfg.mosi_oe_n & cfg.miso_oe_n);
	endproperty
	a_bidir_master_off: assert property (p_bidir_master_off)
		else $error("master bidir pins driven with output off");

	property p_slave_ss_input;
		slv |-> (cfg.ss_oe_n & ~cfg.ss_fault_in);
	endproperty
	a_slave_ss_input: assert property (p_slave_ss_input)
		else $error("slave select not an input in slave mode");

	property p_normal_pins;
		(cfg.enable & ~bidir) |-> (cfg.mosi_oe_n == ~cfg.master)
			&& (cfg.miso_oe_n == cfg.master);
	endproperty
	a_normal_pins: assert property (p_normal_pins)
		else $error("normal pin directions wrong");
endmodule : serial_pin_mux

// ==== hdl/spi_control_config.sv ====
// Control registers, abort detection and link sampling of the serial port
//
// Behaviour
// - Done or fault flag interrupts need general enable
// - Module enable gives pins; clear forces idle
// - Transmit empty interrupt needs transmit enable
// - Role bit picks master; change forces idle
// - Polarity bit sets serial clock rest level
// - Both ends need equal clock polarity
// - Phase bit picks odd or even sample edges; here only slave sampling follows it, no phase output reaches the master
// - Master format change aborts transfer, forces idle
// - Select pin use follows fault and output enables
// - Low bit first option; register keeps top bit
// - Width bit selects 8 or 16 bits
// - Fault detect only in master; slave select input
// - Bidirectional output enable gates the shared pin
// - Master bidir output enable change aborts transfer; here only while pin control selects single pin
// - Wait stop bit halts clock in wait
// - Pin control picks normal or single pin
// - Controls always accessible; reserved writes ignored
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module spi_control_config
	import serial_ctrl_pkg::*;
(
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic transfer_done_flag_in,
	input wire logic mode_fault_flag_in,
	input wire logic tx_empty_flag_in,
	input wire logic wait_mode_in,
	input wire logic ss_pin_in,
	input wire logic sck_pin_in,
	output logic irq_out,
	output logic force_idle_out,
	output logic flags_reset_out,
	output logic sck_gen_enable_out,
	output logic sck_idle_level_out,
	output logic low_bit_first_out,
	output logic [4:0] transfer_bits_out,
	output logic sample_strobe_out,
	output logic mode_fault_detect_out,
	output logic mosi_oe_n_out,
	output logic miso_oe_n_out,
	output logic ss_oe_n_out,
	output logic sck_oe_n_out,
	output logic rx_on_mosi_out
);
	////////////////////////////////////////////////////////////////////////
	logic [7:0] one_ff;
	logic [7:0] two_ff;
	logic [IRQ_W-1:0] stat_ff;
	logic [IRQ_W-1:0] mask_ff;
	logic [31:0] rdata_ff;
	logic abort_ff;
	logic ss_s1_ff;
	logic ss_s2_ff;
	logic sck_s1_ff;
	logic sck_s2_ff;
	logic sck_d_ff;
	logic parity_ff;
	logic fault_d_ff;
	logic fault_pulse_ff;
	link_state_e link_ff;
	link_state_e nxt_link;
	pin_cfg_if pins ();
	////////////////////////////////////////////////////////////////////////
	// Bus decode
	wire logic setup = psel_in & ~penable_in;
	wire logic access = psel_in & penable_in;
	wire logic sel_one = paddr_in == reg_addr(IDX_CTRL_ONE);
	wire logic sel_two = paddr_in == reg_addr(IDX_CTRL_TWO);
	wire logic sel_stat = paddr_in == reg_addr(IDX_IRQ_STAT);
	wire logic sel_mask = paddr_in == reg_addr(IDX_IRQ_MASK);
	wire logic hit = sel_one | sel_two | sel_stat | sel_mask;
	wire logic wr_en = access & pwrite_in & hit;
	// Zero wait states; unmapped addresses answer with an error
	assign pready_out = access;
	assign pslverr_out = access & ~hit;
	assign prdata_out = rdata_ff;
	wire logic [31:0] rd_mux =
		sel_one ? {24'h000000, one_ff} :
		sel_two ? {24'h000000, two_ff} :
		sel_stat ? {29'h00000000, stat_ff} :
		sel_mask ? {29'h00000000, mask_ff} : 32'h00000000;
	////////////////////////////////////////////////////////////////////////
	// Control register next values
	wire logic [7:0] nxt_one = (wr_en & sel_one) ? pwdata_in[7:0] : one_ff;
	wire logic [7:0] nxt_two = (wr_en & sel_two) ?
		(pwdata_in[7:0] & CTRL_TWO_MASK) : two_ff;
	wire logic [7:0] diff_one = nxt_one ^ one_ff;
	wire logic [7:0] diff_two = nxt_two ^ two_ff;
	wire logic enable = one_ff[B_ENA];
	wire logic master = one_ff[B_ROLE];
	// Role change aborts in either mode; format changes only as master
	wire logic role_chg = diff_one[B_ROLE];
	wire logic fmt_chg = master & ((|(diff_one & CTRL_ONE_ABORT)) |
		(|(diff_two & CTRL_TWO_ABORT)));
	wire logic boe_chg = master & two_ff[B_PIN] & diff_two[B_BOE];
	wire logic nxt_abort = role_chg | fmt_chg | boe_chg;
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			one_ff <= CTRL_RESET;
			two_ff <= CTRL_RESET;
			abort_ff <= 1'b0;
		end else begin
			one_ff <= nxt_one;
			two_ff <= nxt_two;
			abort_ff <= nxt_abort;
		end
	end
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rdata_ff <= 32'h00000000;
		end else if (setup) begin
			rdata_ff <= rd_mux;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Link input synchronisers
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ss_s1_ff <= 1'b1;
			ss_s2_ff <= 1'b1;
			sck_s1_ff <= 1'b0;
			sck_s2_ff <= 1'b0;
			sck_d_ff <= 1'b0;
		end else begin
			ss_s1_ff <= ss_pin_in;
			ss_s2_ff <= ss_s1_ff;
			sck_s1_ff <= sck_pin_in;
			sck_s2_ff <= sck_s1_ff;
			sck_d_ff <= sck_s2_ff;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Slave frame tracking and sample edge selection
	wire logic slave_on = enable & ~master;
	wire logic sck_edge = sck_s2_ff ^ sck_d_ff;
	wire logic selected = slave_on & ~ss_s2_ff;
	wire logic frame_start = (link_ff == LK_IDLE) & selected;
	always_comb begin
		nxt_link = link_ff;
		case (link_ff)
			LK_IDLE: begin
				if (selected) begin
					nxt_link = LK_ACTIVE;
				end
			end
			LK_ACTIVE: begin
				if (~selected | force_idle_out) begin
					nxt_link = LK_IDLE;
				end
			end
			default: begin
				nxt_link = LK_IDLE;
			end
		endcase
	end
	// Parity counts edges seen; zero before the first edge
	wire logic in_frame = (link_ff == LK_ACTIVE) & selected;
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			link_ff <= LK_IDLE;
			parity_ff <= 1'b0;
		end else begin
			link_ff <= nxt_link;
			if (~in_frame | force_idle_out) begin
				parity_ff <= 1'b0;
			end else if (sck_edge) begin
				parity_ff <= ~parity_ff;
			end
		end
	end
	// Odd edges have parity zero; even edges parity one
	assign sample_strobe_out = in_frame & ~force_idle_out & sck_edge &
		(parity_ff == one_ff[B_CLOCK_PHASE]);
	////////////////////////////////////////////////////////////////////////
	// Mode fault detection as master with the select pin as input
	wire logic fault_cond = pins.ss_fault_in & ~ss_s2_ff;
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			fault_d_ff <= 1'b0;
			fault_pulse_ff <= 1'b0;
		end else begin
			fault_d_ff <= fault_cond;
			fault_pulse_ff <= fault_cond & ~fault_d_ff;
		end
	end
	assign mode_fault_detect_out = fault_pulse_ff;
	////////////////////////////////////////////////////////////////////////
	// Interrupts: sticky status, write one to clear, set beats clear
	wire logic [IRQ_W-1:0] irq_event = {frame_start, fault_pulse_ff,
		abort_ff};
	wire logic [IRQ_W-1:0] irq_clr = (wr_en & sel_stat) ?
		pwdata_in[IRQ_W-1:0] : IRQ_RESET;
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			stat_ff <= IRQ_RESET;
			mask_ff <= IRQ_RESET;
		end else begin
			stat_ff <= (stat_ff & ~irq_clr) | irq_event;
			if (wr_en & sel_mask) begin
				mask_ff <= pwdata_in[IRQ_W-1:0];
			end
		end
	end
	wire logic flag_req = enable & one_ff[B_GIE] &
		(transfer_done_flag_in | mode_fault_flag_in);
	wire logic tx_req = enable & one_ff[B_TXIE] & tx_empty_flag_in;
	assign irq_out = flag_req | tx_req | (|(stat_ff & mask_ff));
	////////////////////////////////////////////////////////////////////////
	// Outputs to shifter, baud divider and status logic
	assign force_idle_out = abort_ff | ~enable;
	assign flags_reset_out = ~enable;
	// Slave keeps following the master clock during wait
	assign sck_gen_enable_out = enable & master &
		~(wait_mode_in & two_ff[B_WCS]);
	assign sck_idle_level_out = one_ff[B_CLOCK_POLARITY];
	// Shift order only; data register layout never changes
	assign low_bit_first_out = one_ff[B_LSBF];
	assign transfer_bits_out = two_ff[B_TRANSFER_WIDTH_SEL] ? BITS_WIDE :
		BITS_NARROW;
	////////////////////////////////////////////////////////////////////////
	// Pin mux
	assign pins.enable = enable;
	assign pins.master = master;
	assign pins.pin_ctl = two_ff[B_PIN];
	assign pins.bidir_oe = two_ff[B_BOE];
	assign pins.mode_fault_flag_en = two_ff[B_MODE_FAULT_FLAG];
	assign pins.ss_oe = one_ff[B_SELECT_OUTPUT_ENABLE];

	serial_pin_mux u_pin_mux (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.cfg(pins.mux)
	);

	assign mosi_oe_n_out = pins.mosi_oe_n;
	assign miso_oe_n_out = pins.miso_oe_n;
	assign ss_oe_n_out = pins.ss_oe_n;
	assign sck_oe_n_out = pins.sck_oe_n;
	assign rx_on_mosi_out = pins.rx_on_mosi;

	////////////////////////////////////////////////////////////////////////
	// Checks
	logic [2:0] edge_chk_ff;
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			edge_chk_ff <= 3'h0;
		end else if (~in_frame | force_idle_out) begin
			edge_chk_ff <= 3'h0;
		end else if (sck_edge) begin
			edge_chk_ff <= edge_chk_ff + 3'h1;
		end
	end

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);

	property p_flag_irq;
		(one_ff[B_GIE] & enable & $rose(transfer_done_flag_in)) |-> irq_out;
	endproperty
	a_flag_irq: assert property (p_flag_irq)
		else $error("done flag without interrupt");

	property p_irq_quiet;
		(~one_ff[B_GIE] & ~one_ff[B_TXIE] & ~(|(stat_ff & mask_ff)))
			|-> ~irq_out;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet)
		else $error("interrupt while all enables off");

	property p_disabled;
		~enable |-> (flags_reset_out & force_idle_out & mosi_oe_n_out &
			miso_oe_n_out & ss_oe_n_out & sck_oe_n_out);
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("disabled module not idle");

	property p_tx_irq;
		(enable & one_ff[B_TXIE] & tx_empty_flag_in) |-> irq_out;
	endproperty
	a_tx_irq: assert property (p_tx_irq)
		else $error("transmit empty without interrupt");

	property p_role_abort;
		(wr_en & sel_one & (pwdata_in[B_ROLE] != one_ff[B_ROLE]))
			|=> force_idle_out ##1 (abort_ff == 1'b0);
	endproperty
	a_role_abort: assert property (p_role_abort)
		else $error("role change did not force idle");

	property p_master_idle;
		(enable & master) |-> (~sck_oe_n_out &&
			sck_idle_level_out == one_ff[B_CLOCK_POLARITY]);
	endproperty
	a_master_idle: assert property (p_master_idle)
		else $error("master clock rest level wrong");

	property p_sample_edge;
		sample_strobe_out |-> (edge_chk_ff[0] == one_ff[B_CLOCK_PHASE]);
	endproperty
	a_sample_edge: assert property (p_sample_edge)
		else $error("sample on wrong edge number");

	property p_fmt_abort;
		(master & $changed(one_ff[B_CLOCK_POLARITY])) |-> force_idle_out;
	endproperty
	a_fmt_abort: assert property (p_fmt_abort)
		else $error("polarity change in master did not abort");

	property p_bidir_abort;
		(master & two_ff[B_PIN] & $changed(two_ff[B_BOE])) |->
			abort_ff;
	endproperty
	a_bidir_abort: assert property (p_bidir_abort)
		else $error("bidir output enable change did not abort");

	property p_ss_out;
		(enable & master & two_ff[B_MODE_FAULT_FLAG] & one_ff[B_SELECT_OUTPUT_ENABLE]) |->
			~ss_oe_n_out;
	endproperty
	a_ss_out: assert property (p_ss_out)
		else $error("select output not driven");

	property p_fault;
		(pins.ss_fault_in & $fell(ss_s2_ff) & $stable(pins.ss_fault_in))
			|=> mode_fault_detect_out;
	endproperty
	a_fault: assert property (p_fault)
		else $error("mode fault not detected");

	property p_wait_stop;
		(wait_mode_in & two_ff[B_WCS]) |-> ~sck_gen_enable_out;
	endproperty
	a_wait_stop: assert property (p_wait_stop)
		else $error("clock runs in wait with stop set");

	property p_width;
		transfer_bits_out == (two_ff[B_TRANSFER_WIDTH_SEL] ? 5'h10 : 5'h08);
	endproperty
	a_width: assert property (p_width)
		else $error("transfer width wrong");

	property p_reserved;
		(wr_en & sel_two) |=> ((two_ff & ~CTRL_TWO_MASK) == 8'h00);
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved control bit stored");

	c_abort: cover property (abort_ff & master);
	c_sample: cover property (sample_strobe_out & one_ff[B_CLOCK_PHASE]);
	c_fault: cover property (mode_fault_detect_out);
	c_irq: cover property (irq_out & (|(stat_ff & mask_ff)));
endmodule : spi_control_config

// ==== pkg/pin_cfg_if.sv ====
// Configuration and pin direction signals between control and pin mux
`timescale 1ns/1ps
interface pin_cfg_if;
	logic enable;
	logic master;
	logic pin_ctl;
	logic bidir_oe;
	logic mode_fault_flag_en;
	logic ss_oe;
	logic mosi_oe_n;
	logic miso_oe_n;
	logic ss_oe_n;
	logic sck_oe_n;
	logic rx_on_mosi;
	logic ss_fault_in;
	modport cfg (
		output enable, master, pin_ctl, bidir_oe, mode_fault_flag_en, ss_oe,
		input mosi_oe_n, miso_oe_n, ss_oe_n, sck_oe_n, rx_on_mosi,
		input ss_fault_in
	);
	modport mux (
		input enable, master, pin_ctl, bidir_oe, mode_fault_flag_en, ss_oe,
		output mosi_oe_n, miso_oe_n, ss_oe_n, sck_oe_n, rx_on_mosi,
		output ss_fault_in
	);
endinterface : pin_cfg_if

// ==== pkg/serial_ctrl_pkg.sv ====
// Constants shared by the serial control block and its testbench
package serial_ctrl_pkg;
	localparam int ADDR_W = 12;
	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_CTRL_ONE = 10'h000;
	localparam logic [9:0] IDX_CTRL_TWO = 10'h001;
	localparam logic [9:0] IDX_IRQ_STAT = 10'h008;
	localparam logic [9:0] IDX_IRQ_MASK = 10'h009;
	// Control one field positions
	localparam int B_GIE = 7;
	localparam int B_ENA = 6;
	localparam int B_TXIE = 5;
	localparam int B_ROLE = 4;
	localparam int B_CLOCK_POLARITY = 3;
	localparam int B_CLOCK_PHASE = 2;
	localparam int B_SELECT_OUTPUT_ENABLE = 1;
	localparam int B_LSBF = 0;
	// Control two field positions
	localparam int B_TRANSFER_WIDTH_SEL = 6;
	localparam int B_MODE_FAULT_FLAG = 4;
	localparam int B_BOE = 3;
	localparam int B_WCS = 1;
	localparam int B_PIN = 0;
	localparam logic [7:0] CTRL_TWO_MASK = 8'h5B;
	localparam logic [7:0] CTRL_ONE_ABORT = 8'h0F;
	localparam logic [7:0] CTRL_TWO_ABORT = 8'h51;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// Interrupt status bits
	localparam int IRQ_W = 3;
	localparam int I_ABORT = 0;
	localparam int I_FAULT = 1;
	localparam int I_FRAME = 2;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;
	localparam logic [4:0] BITS_NARROW = 5'h08;
	localparam logic [4:0] BITS_WIDE = 5'h10;
	typedef enum logic [1:0] {
		LK_IDLE = 2'b00,
		LK_ACTIVE = 2'b01
	} link_state_e;
	function automatic logic [ADDR_W-1:0] reg_addr(input logic [9:0] idx);
		reg_addr = {idx, 2'b00};
	endfunction : reg_addr
endpackage : serial_ctrl_pkg

// ==== verification/serial_far_end.sv ====
// Behavioural far-side master: drives select and serial clock pins
`timescale 1ns/1ps
module serial_far_end (
	output logic ss_out,
	output logic sck_out
);
	initial begin
		ss_out = 1'b1;
		sck_out = 1'b0;
	end
	// Select only; clock stays at rest
	task automatic select(input logic on);
		#3 ss_out = ~on;
	endtask : select
	// Clock rests at the agreed polarity outside a frame
	task automatic frame(input int n, input logic pol);
		#3 sck_out = pol;
		#40 ss_out = 1'b0;
		#100;
		repeat (n) #32 sck_out = ~sck_out;
		#100 ss_out = 1'b1;
		sck_out = pol;
		#50;
	endtask : frame
endmodule : serial_far_end

// ==== verification/tb.sv ====
// Self-checking bench for the serial control block
`timescale 1ns/1ps
module tb;
	import serial_ctrl_pkg::*;
	localparam logic [11:0] A_ONE = {IDX_CTRL_ONE, 2'b00};
	localparam logic [11:0] A_TWO = {IDX_CTRL_TWO, 2'b00};
	localparam logic [11:0] A_STAT = {IDX_IRQ_STAT, 2'b00};
	localparam logic [11:0] A_MASK = {IDX_IRQ_MASK, 2'b00};
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err;
	logic done_f = 1'b0, fault_f = 1'b0, txe_f = 1'b0, wait_m = 1'b0;
	logic ss_pin, sck_pin, irq, f_idle, f_rst, sck_gen, sck_idle, lbf;
	logic strobe, mf_det, mosi_n, miso_n, ss_n, sck_n, rx_mosi;
	logic [4:0] bits;
	int fail_count = 0, n_compared = 0, idle_cnt, mf_cnt, st_cnt;
	always #4 clk_in = ~clk_in;
	spi_control_config uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
		.paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr),
		.transfer_done_flag_in(done_f), .mode_fault_flag_in(fault_f),
		.tx_empty_flag_in(txe_f), .wait_mode_in(wait_m),
		.ss_pin_in(ss_pin), .sck_pin_in(sck_pin), .irq_out(irq),
		.force_idle_out(f_idle), .flags_reset_out(f_rst),
		.sck_gen_enable_out(sck_gen), .sck_idle_level_out(sck_idle),
		.low_bit_first_out(lbf), .transfer_bits_out(bits),
		.sample_strobe_out(strobe), .mode_fault_detect_out(mf_det),
		.mosi_oe_n_out(mosi_n), .miso_oe_n_out(miso_n),
		.ss_oe_n_out(ss_n), .sck_oe_n_out(sck_n),
		.rx_on_mosi_out(rx_mosi));
	serial_far_end far (.ss_out(ss_pin), .sck_out(sck_pin));
	// Counted at negedge so the tasks can clear them at posedge
	always @(negedge clk_in) begin
		if (f_idle === 1'b1) idle_cnt++;
		if (mf_det === 1'b1) mf_cnt++;
		if (strobe === 1'b1) st_cnt++;
	end
	////////////////////////////////////////////////////////////////////
	task automatic results;
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : results
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int i;
		@(posedge clk_in);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_in);
		pen <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_in);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			fail_count++;
			results();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	task automatic settle;
		@(negedge clk_in);
	endtask : settle
	////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		apb(0, A_ONE, 0);
		chk(rd, 32'h0);
		apb(0, A_TWO, 0);
		chk(rd, 32'h0);
		settle();
		chk({f_idle, f_rst}, 2'h3);
		chk({mosi_n, miso_n, ss_n, sck_n}, 4'hF);
		chk(bits, BITS_NARROW);
		$display("test reset done");
	endtask : t_reset
	task automatic t_regs;
		@(posedge clk_in);
		wait_m <= 1'b1;
		apb(1, A_ONE, 32'h000000FF);
		apb(0, A_ONE, 0);
		chk(rd, 32'hFF);
		apb(1, A_TWO, 32'hFFFFFFFF);
		apb(0, A_TWO, 0);
		chk(rd, 32'h5B);
		apb(1, 12'h010, 32'hFF);
		chk(err, 1'b1);
		apb(0, 12'h010, 0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		settle();
		chk({bits, lbf, sck_idle, sck_gen}, {BITS_WIDE, 3'b110});
		apb(1, A_TWO, 32'h58);
		settle();
		chk({sck_gen, sck_idle, bits}, {2'b11, BITS_WIDE});
		apb(1, A_ONE, 32'h40);
		settle();
		chk({lbf, sck_idle, bits}, {2'b00, BITS_WIDE});
		@(posedge clk_in);
		wait_m <= 1'b0;
		$display("test regs done");
	endtask : t_regs
	task automatic t_pins;
		logic [15:0] c [8] = '{16'h5000, 16'h5001, 16'h5009, 16'h4000,
			16'h4001, 16'h4009, 16'h5210, 16'h4210};
		logic [4:0] e [8] = '{5'h0C, 5'h1D, 5'h0D, 5'h17, 5'h1E,
			5'h16, 5'h08, 5'h17};
		for (int k = 0; k < 8; k++) begin
			apb(1, A_ONE, {24'h0, c[k][15:8]});
			apb(1, A_TWO, {24'h0, c[k][7:0]});
			settle();
			chk({mosi_n, miso_n, ss_n, sck_n, rx_mosi}, e[k]);
		end
		$display("test pins done");
	endtask : t_pins
	task automatic t_irq;
		apb(1, A_TWO, 0);
		apb(1, A_ONE, 32'h40);
		done_f <= 1'b1;
		settle();
		chk(irq, 1'b0);
		apb(1, A_ONE, 32'hC0);
		settle();
		chk(irq, 1'b1);
		@(posedge clk_in);
		done_f <= 1'b0;
		fault_f <= 1'b1;
		settle();
		chk(irq, 1'b1);
		@(posedge clk_in);
		fault_f <= 1'b0;
		txe_f <= 1'b1;
		settle();
		chk(irq, 1'b0);
		apb(1, A_ONE, 32'h60);
		settle();
		chk(irq, 1'b1);
		@(posedge clk_in);
		txe_f <= 1'b0;
		settle();
		chk(irq, 1'b0);
		$display("test irq done");
	endtask : t_irq
	task automatic t_abort;
		logic [8:0] w [11] = '{9'h050, 9'h058, 9'h05C, 9'h05E, 9'h05F,
			9'h140, 9'h150, 9'h151, 9'h159, 9'h15B, 9'h04F};
		logic [10:0] ab = 11'b10111111110;
		apb(1, A_ONE, 32'h50);
		apb(1, A_TWO, 0);
		apb(1, A_STAT, 32'h7);
		for (int k = 0; k < 11; k++) begin
			apb(1, w[k][8] ? A_TWO : A_ONE, {24'h0, w[k][7:0]});
			idle_cnt = 0;
			repeat (4) settle();
			chk(idle_cnt, ab[k]);
		end
		apb(0, A_STAT, 0);
		chk(rd[I_ABORT], 1'b1);
		apb(1, A_MASK, 32'h1);
		settle();
		chk(irq, 1'b1);
		apb(1, A_STAT, 32'h1);
		apb(0, A_STAT, 0);
		chk({irq, rd[I_ABORT]}, 2'b00);
		$display("test abort done");
	endtask : t_abort
	task automatic t_fault;
		apb(1, A_ONE, 32'h50);
		apb(1, A_TWO, 32'h10);
		mf_cnt = 0;
		far.select(1'b1);
		repeat (10) settle();
		chk(mf_cnt != 0, 1'b1);
		far.select(1'b0);
		apb(1, A_ONE, 32'h40);
		repeat (6) settle();
		mf_cnt = 0;
		far.select(1'b1);
		repeat (10) settle();
		chk(mf_cnt, 0);
		far.select(1'b0);
		$display("test fault done");
	endtask : t_fault
	task automatic t_frame;
		for (int k = 0; k < 3; k++) begin
			apb(1, A_ONE, k == 2 ? 32'h48 : (k == 1 ? 32'h44 : 32'h40));
			repeat (6) settle();
			st_cnt = 0;
			far.frame(3, k == 2);
			repeat (4) settle();
			chk(st_cnt, k == 1 ? 1 : 2);
		end
		apb(0, A_STAT, 0);
		chk(rd[I_FRAME], 1'b1);
		apb(1, A_ONE, 32'h00);
		settle();
		chk({f_idle, f_rst}, 2'h3);
		$display("test frame done");
	endtask : t_frame
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		t_reset();
		t_regs();
		t_pins();
		t_irq();
		t_abort();
		t_fault();
		t_frame();
		results();
	end
endmodule : tb
